//--- drc_cfg.svh
`ifndef DRC_CFG_SVH
`define DRC_CFG_SVH
// Queue and read buffer geometry
`define DRC_QDEPTH      4
`define DRC_BUF_DEPTH   64
// Target-bus attempts before a read is abandoned (two to the 24th)
`define DRC_RETRY_LIMIT 16777216
// Empty-buffer clocks tolerated in flow-through
`define DRC_FT_STALL    8
// Clocks without DEVSEL# before a master abort
`define DRC_MABORT_CLKS 5
`define DRC_TMR_W       16
// Bus commands
`define DRC_CMD_MRD     4'h6
`define DRC_CMD_MRM     4'hC
`define DRC_CMD_MRL     4'hE
`define DRC_CMD_CFGRD   4'hA
`define DRC_CMD_CFGWR   4'hB
// All byte lanes enabled
`define DRC_BE_ALL      4'h0
// Configuration address format
`define DRC_CFG_T0      2'h0
`define DRC_CFG_T1      2'h1
`define DRC_BUS_MSB     23
`define DRC_BUS_LSB     16
`define DRC_DEV_MSB     15
`define DRC_DEV_LSB     11
`define DRC_FUNC_MSB    10
`define DRC_FUNC_LSB    8
`define DRC_REG_MSB     7
`define DRC_REG_LSB     2
// Word index within a 4KB page
`define DRC_PG_MSB      11
`define DRC_PG_LSB      2
`define DRC_PG_END      10'h3FF
`endif

//--- drc_pkg.sv
`default_nettype none
`include "drc_cfg.svh"
package drc_pkg;
  typedef enum logic [3:0] {
    T_IDLE = 4'b0001,
    T_REQ  = 4'b0010,
    T_ADDR = 4'b0100,
    T_DATA = 4'b1000
  } drc_tstate_e;
  typedef enum logic [1:0] {
    I_IDLE = 2'b01,
    I_XFER = 2'b10
  } drc_istate_e;
  typedef logic [3:0] drc_cmd_t;

  // Memory read flavours compare equal to each other
  function automatic logic drc_cmd_eq(input drc_cmd_t a, input drc_cmd_t b);
    logic ma;
    logic mb;
    ma = (a == `DRC_CMD_MRD) | (a == `DRC_CMD_MRM) | (a == `DRC_CMD_MRL);
    mb = (b == `DRC_CMD_MRD) | (b == `DRC_CMD_MRM) | (b == `DRC_CMD_MRL);
    return (a == b) | (ma & mb);
  endfunction
endpackage
`default_nettype wire

//--- drc_cfg_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "drc_cfg.svh"
module drc_cfg_decode
  import drc_pkg::*;
#(
  parameter bit MULTI_FUNC = 1'b0
) (
  // Address phase
  input  wire logic [31:0] addr,
  input  wire drc_cmd_t    cmd,
  input  wire logic        idsel,
  // Decoded format and fields
  output logic             type0,
  output logic             type1,
  output logic [7:0]       bus_num,
  output logic [4:0]       dev_num,
  output logic [2:0]       func_num,
  output logic [5:0]       reg_num,
  output logic             own_hit
);
  wire is_cfg = (cmd == `DRC_CMD_CFGRD) | (cmd == `DRC_CMD_CFGWR);

  // Format from the two low address bits
  assign type0 = is_cfg & (addr[1:0] == `DRC_CFG_T0);
  assign type1 = is_cfg & (addr[1:0] == `DRC_CFG_T1);

  // Address fields; register number is a DWORD index
  assign bus_num  = addr[`DRC_BUS_MSB:`DRC_BUS_LSB];
  assign dev_num  = addr[`DRC_DEV_MSB:`DRC_DEV_LSB];
  assign reg_num  = addr[`DRC_REG_MSB:`DRC_REG_LSB];
  // Single-function parts leave the function field undecoded
  assign func_num = MULTI_FUNC ? addr[`DRC_FUNC_MSB:`DRC_FUNC_LSB] : 3'h0;

  // Memory and I/O cycles can never reach our own registers
  assign own_hit = type0 & idsel;
endmodule
`default_nettype wire

//--- drc_engine.sv
`timescale 1ns/1ps
`default_nettype none
`include "drc_cfg.svh"
// Overview of operation
// - A new read is stored with address, command, parity, byte enables, then retried.
// - Queued read is replayed on target bus with exact stored address and command.
// - Nonprefetchable read drives stored byte enables in the cycle after address.
// - Prefetchable read drives stored first enables, then all lanes enabled.
// - Target retry makes the same read reissue until data or error.
// - After any data, master end or disconnect stops further fetches for it.
// - After two to the 24th empty attempts, drop entry, answer target abort.
// - Retry limit exhaustion raises system error only when its enable is set.
// - Once DEVSEL# and TRDY# come, one word per clock, no master waits.
// - Deliver only when target read done or flow-through allowed, data at head, write ordering met.
// - Memory read, read line and read multiple match each other.
// - Disconnect is signalled together with the final delivered word.
// - Undelivered data is dropped when the initiator ends early.
// - Flow-through starts when initiator takes prefetch data while target read runs.
// - Flow-through read ends on initiator end, 4KB boundary or full buffer.
// - Empty buffer in flow-through holds TRDY# off at most 8 clocks, then disconnects.
// - Initiator ending flow-through ends the target read and drops buffered data.
// - Discard timer starts from programmed value when completion heads both queues.
// - Discard timer expiry drops entry and data, raising system error if enabled.
// - Up to four delayed reads are held at once.
// - A read matching a queued one makes no second entry.
// - Configuration address bits 1:0 of 00b mean Type-0, 01b Type-1.
// - Type-1 fields: bus, 5-bit device, function, DWORD register number.
// - Own registers answer configuration cycles only, never memory or I/O.
module drc_engine
  import drc_pkg::*;
#(
  parameter int QDEPTH      = `DRC_QDEPTH,
  parameter int BUF_DEPTH   = `DRC_BUF_DEPTH,
  parameter int RETRY_LIMIT = `DRC_RETRY_LIMIT,
  parameter int TMR_W       = `DRC_TMR_W,
  parameter bit MULTI_FUNC  = 1'b0
) (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // Configuration levels
  input  wire logic                  sys_err_en,
  input  wire logic [TMR_W-1:0]      discard_init,
  input  wire logic [$clog2(BUF_DEPTH):0] prefetch_words,
  input  wire logic                  order_ok,
  // Initiator bus
  input  wire logic                  ini_req,
  input  wire logic [31:0]           ini_addr,
  input  wire drc_cmd_t              ini_cmd,
  input  wire logic [3:0]            ini_be,
  input  wire logic                  ini_pref,
  input  wire logic                  ini_idsel,
  input  wire logic                  ini_frame_n,
  input  wire logic                  ini_irdy_n,
  output logic                       ini_retry,
  output logic                       ini_abort,
  output logic                       ini_trdy_n,
  output logic                       ini_stop_n,
  output logic [31:0]                ini_data,
  // Configuration decode
  output logic                       cfg_type0,
  output logic                       cfg_type1,
  output logic [7:0]                 cfg_bus,
  output logic [4:0]                 cfg_dev,
  output logic [2:0]                 cfg_func,
  output logic [5:0]                 cfg_reg,
  output logic                       own_cfg_hit,
  // Target bus
  output logic                       tgt_req_n,
  input  wire logic                  tgt_gnt_n,
  output logic                       tgt_frame_n,
  output logic                       tgt_irdy_n,
  output logic [31:0]                tgt_ad,
  output logic [3:0]                 tgt_cbe,
  input  wire logic                  tgt_devsel_n,
  input  wire logic                  tgt_trdy_n,
  input  wire logic                  tgt_stop_n,
  input  wire logic [31:0]           tgt_ad_in,
  // System error
  output logic                       primary_system_error_out
);
  localparam int QW = $clog2(QDEPTH);
  localparam int BW = $clog2(BUF_DEPTH);
  localparam logic [24:0]   RL_LAST    = 25'(RETRY_LIMIT - 1);
  localparam logic [BW:0]   BUF_LAST   = (BW + 1)'(BUF_DEPTH - 1);
  localparam logic [2:0]    STALL_LAST = 3'(`DRC_FT_STALL - 1);
  localparam logic [2:0]    MA_LAST    = 3'(`DRC_MABORT_CLKS - 1);

  if (QDEPTH < 2 || (1 << QW) != QDEPTH || BUF_DEPTH < 4 || (1 << BW) != BUF_DEPTH ||
      RETRY_LIMIT < 1 || RETRY_LIMIT > 33554432 || TMR_W < 1)
  begin : g_chk
    $error("drc_engine: unsupported parameter values");
  end

  function automatic logic [QW-1:0] first_idx(input logic [QDEPTH-1:0] v);
    logic [QW-1:0] r;
    r = '0;
    for (int k = QDEPTH - 1; k >= 0; k--)
    begin
      if (v[k])
      begin
        r = QW'(k);
      end
    end
    return r;
  endfunction

  // Reset release through two flops
  logic rst_meta_q;
  logic rst_sync_n;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  drc_tstate_e        tst_q;
  drc_istate_e        ist_q;
  logic [QDEPTH-1:0]  q_v_q;
  logic [QDEPTH-1:0]  q_pref_q;
  logic [QDEPTH-1:0]  q_abt_q;
  logic [QDEPTH-1:0]  q_hit;
  logic [31:0]        q_addr_q [QDEPTH];
  drc_cmd_t           q_cmd_q  [QDEPTH];
  logic [3:0]         q_be_q   [QDEPTH];
  logic               q_par_q  [QDEPTH];
  logic [QW-1:0]      cur_q;
  logic               cur_v_q;
  logic               cur_done_q;
  logic               kill_q;
  logic               ft_q;
  logic               first_q;
  logic [24:0]        att_q;
  logic [2:0]         dsel_q;
  logic [2:0]         stall_q;
  logic [9:0]         tw_q;
  logic [BW:0]        tcnt_q;
  logic [TMR_W-1:0]   dtmr_q;
  logic [31:0]        mem [BUF_DEPTH];
  logic [BW-1:0]      wp_q;
  logic [BW-1:0]      rp_q;
  logic [BW:0]        cnt_q;
  logic [BW:0]        cnt_nx;

  // Queue match, one comparator per entry
  for (genvar i = 0; i < QDEPTH; i++)
  begin : g_q
    assign q_hit[i] = q_v_q[i] & (q_addr_q[i] == ini_addr) &
                      drc_cmd_eq(q_cmd_q[i], ini_cmd);
  end

  // Initiator request decisions
  wire cur_pref  = q_pref_q[cur_q];
  wire hit_cur   = cur_v_q & q_hit[cur_q];
  wire is_abt    = q_abt_q[cur_q];
  wire any_hit   = |q_hit;
  wire any_free  = ~&q_v_q;
  wire [QW-1:0] free_idx = first_idx(~q_v_q);
  wire [QW-1:0] pend_idx = first_idx(q_v_q);
  wire ft_ok     = (tst_q == T_DATA) & cur_pref & ~tgt_frame_n & ~kill_q;
  wire ev_req    = ini_req & (ist_q == I_IDLE);
  wire ev_abt_rsp = ev_req & hit_cur & is_abt & cur_done_q;
  wire ev_dlv    = ev_req & hit_cur & ~is_abt & order_ok & (cnt_q != '0) &
                   (cur_done_q | ft_ok);
  wire ev_cap    = ev_req & ~any_hit & any_free;
  wire ev_retry  = ev_req & ~ev_abt_rsp & ~ev_dlv;

  // Target bus events
  wire t_word  = (tst_q == T_DATA) & ~tgt_devsel_n & ~tgt_trdy_n;
  wire t_stop  = (tst_q == T_DATA) & ~tgt_devsel_n & ~tgt_stop_n & tgt_trdy_n;
  wire t_retry = t_stop & first_q;
  wire lim_hit = att_q == RL_LAST;
  wire t_mabt  = (tst_q == T_DATA) & tgt_devsel_n & (dsel_q == MA_LAST);
  wire t_limit = t_retry & lim_hit;
  wire ev_tabort = t_limit | t_mabt;
  wire ev_tdone  = (t_word & (tgt_frame_n | ~tgt_stop_n)) | (t_stop & ~first_q);
  wire t_end   = ev_tdone | ev_tabort | t_retry;
  wire ev_pick = (tst_q == T_IDLE) & ~cur_v_q & (|q_v_q);
  wire ev_gnt  = (tst_q == T_REQ) & ~tgt_gnt_n;

  // Where the burst must stop; buffer room is the only back-pressure
  wire pg_end  = (tw_q + 10'h1) == `DRC_PG_END;
  wire buf_end = cnt_nx >= BUF_LAST;
  wire pf_end  = ~ft_q & ((tcnt_q + (BW + 1)'(2)) >= prefetch_words);
  wire nxt_last = kill_q | ~cur_pref | pg_end | buf_end | pf_end;
  wire [9:0] tw_start = q_addr_q[cur_q][`DRC_PG_MSB:`DRC_PG_LSB];
  wire first_last = ~cur_pref | (tw_q == `DRC_PG_END) |
                    (prefetch_words <= (BW + 1)'(1));

  // Initiator delivery events
  wire i_x     = ist_q == I_XFER;
  wire push    = t_word & ~kill_q;
  wire pop     = i_x & ~ini_irdy_n & (cnt_q != '0);
  wire i_end   = i_x & ini_frame_n;
  wire i_last  = pop & (cnt_q == (BW + 1)'(1)) & cur_done_q;
  wire i_stall = i_x & ~ini_frame_n & (cnt_q == '0);
  wire i_disc  = i_stall & ((stall_q == STALL_LAST) | cur_done_q);
  wire i_fin   = i_last | i_end | i_disc;
  wire dt_run  = cur_v_q & cur_done_q & ~i_x;
  wire ev_drop = dt_run & (dtmr_q == '0) & ~(ev_req & hit_cur);
  wire flush   = ev_drop | i_end | i_disc;
  wire free_cur = ev_abt_rsp | ev_drop | (i_fin & cur_done_q) | (ev_tdone & kill_q);
  assign cnt_nx = flush ? '0 : cnt_q + (BW + 1)'(push) - (BW + 1)'(pop);

  // Per-entry valid and abort marks
  for (genvar i = 0; i < QDEPTH; i++)
  begin : g_qf
    wire cap_here = ev_cap & (free_idx == QW'(i));
    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
      if (!rst_sync_n)
      begin
        q_v_q[i]   <= 1'b0;
        q_abt_q[i] <= 1'b0;
      end
      else
      begin
        q_v_q[i]   <= cap_here | (q_v_q[i] & ~(free_cur & (cur_q == QW'(i))));
        q_abt_q[i] <= cap_here ? 1'b0 : (q_abt_q[i] | (ev_tabort & (cur_q == QW'(i))));
      end
    end
    // Request record, held unchanged for every replay
    always_ff @(posedge clk_sys)
    begin
      if (cap_here)
      begin
        q_addr_q[i] <= ini_addr;
        q_cmd_q[i]  <= ini_cmd;
        q_be_q[i]   <= ini_be;
        q_par_q[i]  <= ^{ini_addr, ini_cmd};
        q_pref_q[i] <= ini_pref;
      end
    end
  end

  // Entry under service
  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      cur_v_q    <= 1'b0;
      cur_q      <= '0;
      cur_done_q <= 1'b0;
      kill_q     <= 1'b0;
      ft_q       <= 1'b0;
    end
    else
    begin
      cur_v_q    <= ev_pick | (cur_v_q & ~free_cur);
      cur_q      <= ev_pick ? pend_idx : cur_q;
      cur_done_q <= ~free_cur & (cur_done_q | ev_tdone | ev_tabort);
      kill_q     <= ~free_cur & (kill_q | (i_fin & ~cur_done_q));
      ft_q       <= ~free_cur & ~ev_pick & (ft_q | (ev_dlv & ~cur_done_q));
    end
  end

  // Target sequencer
  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      tst_q <= T_IDLE;
    end
    else
    begin
      unique case (tst_q)
        T_IDLE: tst_q <= ev_pick ? T_REQ : T_IDLE;
        T_REQ:  tst_q <= ev_gnt ? T_ADDR : T_REQ;
        T_ADDR: tst_q <= T_DATA;
        T_DATA: tst_q <= (t_retry & ~lim_hit) ? T_REQ : (t_end ? T_IDLE : T_DATA);
      endcase
    end
  end

  // Target bus drive; FRAME# high marks the last data phase
  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      tgt_frame_n <= 1'b1;
      tgt_irdy_n  <= 1'b1;
      tgt_ad      <= 32'h0000_0000;
      tgt_cbe     <= 4'h0;
    end
    else if (ev_gnt)
    begin
      tgt_frame_n <= 1'b0;
      tgt_ad      <= q_addr_q[cur_q];
      tgt_cbe     <= q_cmd_q[cur_q];
    end
    else if (tst_q == T_ADDR)
    begin
      tgt_frame_n <= first_last;
      tgt_irdy_n  <= 1'b0;
      tgt_cbe     <= q_be_q[cur_q];
    end
    else if (t_end)
    begin
      tgt_frame_n <= 1'b1;
      tgt_irdy_n  <= 1'b1;
    end
    else if (t_word)
    begin
      tgt_frame_n <= nxt_last;
      tgt_cbe     <= `DRC_BE_ALL;
    end
    else if (kill_q)
    begin
      tgt_frame_n <= 1'b1;
    end
  end
  assign tgt_req_n = tst_q != T_REQ;

  // Attempt, DEVSEL# wait and address counters
  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      att_q   <= 25'h0;
      dsel_q  <= 3'h0;
      first_q <= 1'b1;
      tw_q    <= 10'h000;
      tcnt_q  <= '0;
    end
    else
    begin
      att_q   <= ev_pick ? 25'h0 : (t_retry ? att_q + 25'h1 : att_q);
      dsel_q  <= (tst_q == T_DATA && tgt_devsel_n) ? dsel_q + 3'h1 : 3'h0;
      first_q <= (tst_q == T_ADDR) | (first_q & ~t_word);
      tw_q    <= ev_gnt ? tw_start : (t_word ? tw_q + 10'h1 : tw_q);
      tcnt_q  <= ev_pick ? '0 : (t_word ? tcnt_q + (BW + 1)'(1) : tcnt_q);
    end
  end

  // Read data buffer storage
  always_ff @(posedge clk_sys)
  begin
    if (push & ~flush)
    begin
      mem[wp_q] <= tgt_ad_in;
    end
  end

  // Buffer pointers
  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wp_q  <= flush ? '0 : wp_q + BW'(push);
      rp_q  <= flush ? '0 : rp_q + BW'(pop);
      cnt_q <= cnt_nx;
    end
  end

  // Initiator side state and stall count
  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      ist_q   <= I_IDLE;
      stall_q <= 3'h0;
    end
    else
    begin
      unique case (ist_q)
        I_IDLE: ist_q <= ev_dlv ? I_XFER : I_IDLE;
        I_XFER: ist_q <= i_fin ? I_IDLE : I_XFER;
      endcase
      stall_q <= i_stall ? stall_q + 3'h1 : 3'h0;
    end
  end

  // Initiator answers, all from flops
  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      ini_trdy_n <= 1'b1;
      ini_stop_n <= 1'b1;
      ini_data   <= 32'h0000_0000;
      ini_retry  <= 1'b0;
      ini_abort  <= 1'b0;
    end
    else
    begin
      ini_trdy_n <= ~pop;
      ini_stop_n <= ~(i_last | i_disc);
      ini_data   <= pop ? mem[rp_q] : ini_data;
      ini_retry  <= ev_retry;
      ini_abort  <= ev_abt_rsp;
    end
  end

  // Discard timer; counting stops while a delivery is under way
  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      dtmr_q                   <= '0;
      primary_system_error_out <= 1'b0;
    end
    else
    begin
      dtmr_q <= (ev_tdone | ev_tabort) ? discard_init :
                ((dt_run && dtmr_q != '0) ? dtmr_q - TMR_W'(1) : dtmr_q);
      primary_system_error_out <= sys_err_en & (t_limit | ev_drop);
    end
  end

  // Configuration format, latched with each request
  logic       dec_t0;
  logic       dec_t1;
  logic       dec_own;
  logic [7:0] dec_bus;
  logic [4:0] dec_dev;
  logic [2:0] dec_func;
  logic [5:0] dec_reg;
  drc_cfg_decode #(
    .MULTI_FUNC (MULTI_FUNC)
  ) u_dec (
    .addr     (ini_addr),
    .cmd      (ini_cmd),
    .idsel    (ini_idsel),
    .type0    (dec_t0),
    .type1    (dec_t1),
    .bus_num  (dec_bus),
    .dev_num  (dec_dev),
    .func_num (dec_func),
    .reg_num  (dec_reg),
    .own_hit  (dec_own)
  );
  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      {cfg_type0, cfg_type1, own_cfg_hit} <= 3'h0;
      {cfg_bus, cfg_dev, cfg_func, cfg_reg} <= 22'h0;
    end
    else if (ini_req)
    begin
      {cfg_type0, cfg_type1, own_cfg_hit} <= {dec_t0, dec_t1, dec_own};
      {cfg_bus, cfg_dev, cfg_func, cfg_reg} <= {dec_bus, dec_dev, dec_func, dec_reg};
    end
  end

  default clocking dcb @(posedge clk_sys); endclocking
  default disable iff (!rst_sync_n);

  a_addr_replay: assert property (
    tst_q == T_ADDR |-> !tgt_frame_n && tgt_ad == q_addr_q[cur_q] && tgt_cbe == q_cmd_q[cur_q])
    else $error("address phase differs from stored request");
  a_nonpref_single: assert property (
    tst_q == T_DATA && !cur_pref |-> tgt_frame_n && tgt_cbe == q_be_q[cur_q])
    else $error("nonprefetchable read not a single phase");
  a_pref_all_be: assert property (
    t_word && !tgt_frame_n && !t_end |=> tgt_cbe == `DRC_BE_ALL)
    else $error("later data phase not all lanes enabled");
  a_retry_again: assert property (
    t_retry && !lim_hit |=> tst_q == T_REQ && !tgt_req_n)
    else $error("retried read not reissued");
  a_done_no_fetch: assert property (
    cur_done_q |-> tst_q == T_IDLE && tgt_req_n)
    else $error("fetch restarted after completion");
  a_limit_abort: assert property (
    ini_req && ist_q == I_IDLE && cur_v_q && q_hit[cur_q] && q_abt_q[cur_q] && cur_done_q
    |=> ini_abort && !ini_retry && !q_v_q[$past(cur_q)])
    else $error("retry limit did not yield target abort");
  a_limit_syserr: assert property (
    t_limit |=> primary_system_error_out == $past(sys_err_en))
    else $error("system error wrong on retry limit");
  a_no_wait: assert property (
    tst_q == T_DATA |-> !tgt_irdy_n)
    else $error("master wait state inserted");
  a_last_disc: assert property (
    i_last |=> !ini_stop_n && !ini_trdy_n)
    else $error("last word without disconnect");
  a_stall_bound: assert property (
    i_stall && stall_q == STALL_LAST |=> !ini_stop_n && ist_q == I_IDLE)
    else $error("stall not ended by disconnect");
  a_kill_frame: assert property (
    kill_q && tst_q == T_DATA |=> tgt_frame_n || tst_q != T_DATA)
    else $error("target read not ended after initiator end");
  a_discard_drop: assert property (
    ev_drop |=> !cur_v_q && cnt_q == '0)
    else $error("expired entry not dropped");
  a_no_dup: assert property (
    ev_req && any_hit |=> $countones(q_v_q) == $past($countones(q_v_q)) || !cur_v_q)
    else $error("duplicate request stored");

  c_deliver: cover property (ev_dlv && cur_done_q);
  c_flow:    cover property (ev_dlv && !cur_done_q);
  c_limit:   cover property (ev_abt_rsp);
  c_drop:    cover property (ev_drop);
endmodule
`default_nettype wire

//--- drc_tgt_model.sv
`timescale 1ns/1ps
`default_nettype none
module drc_tgt_model (
  // Clock and behaviour
  input  wire logic        clk_sys,
  input  wire logic        retry_mode,
  input  wire logic [31:0] dbase,
  // Target bus
  input  wire logic        tgt_req_n,
  input  wire logic        tgt_frame_n,
  input  wire logic        tgt_irdy_n,
  input  wire logic [31:0] tgt_ad,
  input  wire logic [3:0]  tgt_cbe,
  output logic             tgt_gnt_n,
  output logic             tgt_devsel_n,
  output logic             tgt_trdy_n,
  output logic             tgt_stop_n,
  output logic [31:0]      tgt_ad_in,
  // What the bridge presented
  output logic [31:0]      cap_ad,
  output logic [3:0]       cap_cmd,
  output logic [3:0]       cap_be,
  output logic [3:0]       late_be
);
  logic act;
  logic take;
  logic fin;
  initial
  begin
    {act, tgt_gnt_n, tgt_devsel_n, tgt_trdy_n, tgt_stop_n} = 5'h0F;
    tgt_ad_in = 32'h0;
  end
  // Sample at the edge, answer 1 ns later like a real target
  always @(posedge clk_sys)
  begin
    take = !tgt_irdy_n && !tgt_trdy_n && !tgt_devsel_n;
    fin = (take && tgt_frame_n) || (!tgt_stop_n && !tgt_irdy_n);
    #1;
    tgt_gnt_n = tgt_req_n;
    if (take)
      late_be = tgt_cbe;
    if (fin)
    begin
      act = 1'b0;
      {tgt_devsel_n, tgt_trdy_n, tgt_stop_n} = 3'h7;
      tgt_ad_in = ~tgt_ad_in; // Released bus never shows stale data
    end
    else if (take)
      tgt_ad_in = tgt_ad_in + 32'h1;
    else if (act && !tgt_irdy_n && tgt_devsel_n)
    begin
      cap_be = tgt_cbe;
      {tgt_devsel_n, tgt_trdy_n, tgt_stop_n} = {1'b0, retry_mode, !retry_mode};
      tgt_ad_in = dbase;
    end
    else if (!act && !tgt_frame_n)
    begin
      act = 1'b1;
      cap_ad = tgt_ad;
      cap_cmd = tgt_cbe;
    end
  end
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "drc_cfg.svh"
module tb_top;
  localparam logic [34:0] RT = {1'b1, 34'h0};
  localparam logic [34:0] AB = {2'h1, 33'h0};
  logic        clk_sys = 1'b0;
  logic        rst_n, sys_err_en, order_ok, ini_req, ini_pref, ini_frame_n, ini_irdy_n;
  logic        ini_retry, ini_abort, ini_trdy_n, ini_stop_n, cfg_type0, cfg_type1;
  logic        tgt_req_n, tgt_gnt_n, tgt_frame_n, tgt_irdy_n, tgt_devsel_n, tgt_trdy_n;
  logic        tgt_stop_n, primary_system_error_out, own_cfg_hit, retry_mode, serr_seen;
  logic        ini_idsel = 1'b1;
  logic [31:0] ini_addr, ini_data, tgt_ad, tgt_ad_in, cap_ad, dbase, a;
  logic [3:0]  ini_cmd, ini_be, tgt_cbe, cap_cmd, cap_be, late_be;
  logic [15:0] discard_init;
  logic [15:0] rnd = 16'h0047;
  logic [6:0]  prefetch_words;
  logic [7:0]  cfg_bus;
  logic [4:0]  cfg_dev;
  logic [2:0]  cfg_func;
  logic [5:0]  cfg_reg;
  logic [34:0] expq[$];
  int          n_fail = 0;
  int          total_checks = 0;

  drc_engine #(.RETRY_LIMIT(4)) drc_engine_i (.clk_sys, .rst_n, .sys_err_en, .discard_init,
    .prefetch_words, .order_ok, .ini_req, .ini_addr, .ini_cmd, .ini_be, .ini_pref, .ini_idsel,
    .ini_frame_n, .ini_irdy_n, .ini_retry, .ini_abort, .ini_trdy_n, .ini_stop_n, .ini_data,
    .cfg_type0, .cfg_type1, .cfg_bus, .cfg_dev, .cfg_func, .cfg_reg, .own_cfg_hit, .tgt_req_n,
    .tgt_gnt_n, .tgt_frame_n, .tgt_irdy_n, .tgt_ad, .tgt_cbe, .tgt_devsel_n, .tgt_trdy_n,
    .tgt_stop_n, .tgt_ad_in, .primary_system_error_out);
  drc_tgt_model drc_tgt_model_i (.clk_sys, .retry_mode, .dbase, .tgt_req_n, .tgt_frame_n,
    .tgt_irdy_n, .tgt_ad, .tgt_cbe, .tgt_gnt_n, .tgt_devsel_n, .tgt_trdy_n, .tgt_stop_n,
    .tgt_ad_in, .cap_ad, .cap_cmd, .cap_be, .late_be);

  always #20 clk_sys = ~clk_sys;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input logic [34:0] seen, input logic [34:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (n_fail == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One-cycle address phase, launched just after the edge
  task automatic rd(input logic [31:0] ad, input logic [3:0] c, input logic p);
    @(posedge clk_sys);
    #1 {ini_req, ini_addr, ini_cmd, ini_pref} = {1'b1, ad, c, p};
    @(posedge clk_sys);
    #1 ini_req = 1'b0;
  endtask

  // Repeat a read and take n words; stop only with the last
  task automatic dlv(input logic [31:0] ad, input logic [3:0] c, input logic p, input int n);
    for (int i = 0; i < n; i++)
      expq.push_back({2'h0, i != n - 1, dbase + i});
    rd(ad, c, p);
    {ini_frame_n, ini_irdy_n} = 2'h0;
    repeat (n + 3) @(posedge clk_sys);
    #1 {ini_frame_n, ini_irdy_n} = 2'h3;
  endtask

  // A fresh read: retried now, fetched by the far side meanwhile
  task automatic fresh(input logic [3:0] c, input logic p, input int w);
    rnd = lfsr(rnd);
    a = {rnd, 16'h0040};
    dbase = {rnd, ~rnd};
    expq.push_back(RT);
    rd(a, c, p);
    repeat (w) @(posedge clk_sys);
  endtask

  // Results are compared against the oldest note
  always @(posedge clk_sys)
  begin
    if (primary_system_error_out === 1'b1)
      serr_seen = 1'b1;
    if (ini_retry || ini_abort || !ini_trdy_n)
      chk({ini_retry, ini_abort, ini_trdy_n ? 33'h0 : {ini_stop_n, ini_data}},
          expq.size() > 0 ? expq.pop_front() : 35'h0);
  end

  initial
  begin
    repeat (3000) @(posedge clk_sys);
    n_fail++;
    complete_run();
  end

  initial
  begin
    {rst_n, ini_req, ini_pref, retry_mode, serr_seen} = 5'h0;
    {sys_err_en, order_ok, ini_frame_n, ini_irdy_n} = 4'hF;
    {ini_addr, dbase, ini_cmd} = 68'h0;
    discard_init = 16'h00C8;
    prefetch_words = 7'h03;
    repeat (5) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    // Nonprefetchable read, repeated with an aliased command
    ini_be = 4'h5;
    fresh(`DRC_CMD_MRD, 1'b0, 30);
    chk({3'h0, cap_ad}, {3'h0, a});
    chk({31'h0, cap_cmd}, {31'h0, `DRC_CMD_MRD});
    chk({31'h0, cap_be}, 35'h5);
    chk({34'h0, own_cfg_hit}, 35'h0);
    dlv(a, `DRC_CMD_MRL, 1'b0, 1);
    // Prefetchable read of three words
    ini_be = 4'h3;
    fresh(`DRC_CMD_MRM, 1'b1, 30);
    chk({27'h0, cap_be, late_be}, {27'h0, 4'h3, `DRC_BE_ALL});
    dlv(a, `DRC_CMD_MRD, 1'b1, 3);
    // Target keeps retrying until the attempt limit
    retry_mode = 1'b1;
    serr_seen = 1'b0;
    fresh(`DRC_CMD_MRD, 1'b0, 50);
    chk({34'h0, serr_seen}, 35'h1);
    retry_mode = 1'b0;
    expq.push_back(AB);
    rd(a, `DRC_CMD_MRD, 1'b0);
    // Completion never collected: discard timer drops it
    fresh(`DRC_CMD_MRD, 1'b0, 30);
    serr_seen = 1'b0;
    repeat (230) @(posedge clk_sys);
    chk({34'h0, serr_seen}, 35'h1);
    expq.push_back(RT);
    rd(a, `DRC_CMD_MRD, 1'b0);
    // Configuration address formats
    for (int t = 0; t < 2; t++)
    begin
      rnd = lfsr(rnd);
      expq.push_back(RT);
      rd({8'h00, rnd, 6'h2A, t[1:0]}, `DRC_CMD_CFGRD, 1'b0);
      chk({32'h0, cfg_type0, cfg_type1, own_cfg_hit}, t == 0 ? 35'h5 : 35'h2);
      chk({13'h0, cfg_bus, cfg_dev, cfg_func, cfg_reg}, {13'h0, rnd[15:3], 3'h0, 6'h2A});
    end
    repeat (60) @(posedge clk_sys);
    chk(35'(expq.size()), 35'h0);
    complete_run();
  end
endmodule
`default_nettype wire
